// ---- hw/lei_pkg.sv ----
// constants, register map and carrier types for the line edge interrupt block
// assumes a single 25 MHz core clock and a plain strobe register port
package lei_pkg;

  // geometry
  localparam int unsigned LEI_LINES = 16;
  localparam int unsigned LEI_ADDR_W = 12;
  localparam int unsigned LEI_DATA_W = 32;
  localparam int unsigned LEI_RISE_LSB = 0;
  localparam int unsigned LEI_FALL_LSB = 16;
  localparam int unsigned LEI_GLOBAL_EN_BIT = 0;

  // register byte offsets
  localparam logic [11:0] LEI_OFS_ENABLE = 12'h114;
  localparam logic [11:0] LEI_OFS_PENDING = 12'h118;
  localparam logic [11:0] LEI_OFS_CTRL = 12'h11c;

  // reset values
  localparam logic [31:0] LEI_ENABLE_RST = 32'h0000_0000;
  localparam logic [31:0] LEI_PENDING_RST = 32'h0000_0000;
  localparam logic [31:0] LEI_RDATA_IDLE = 32'h0000_0000;
  localparam logic [15:0] LEI_LINE_RST = 16'h0000;
  localparam logic LEI_CTRL_RST = 1'b0;

  // register selected by the current access
  typedef enum logic [1:0] {
    LEI_SEL_NONE,
    LEI_SEL_ENABLE,
    LEI_SEL_PENDING,
    LEI_SEL_CTRL
  } lei_sel_t;

  // one register port access
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic we;
    logic re;
  } lei_bus_req_t;

  // all state of the block
  typedef struct packed {
    logic [31:0] enable;
    logic [31:0] pending;
    logic global_irq_enable;
    logic [15:0] line_prev;
    logic primed;
    logic [31:0] rdata;
  } lei_state_t;

endpackage

// ---- hw/lei_top.sv ----
// edge-triggered interrupt logic for sixteen debounced ttl lines
// assumes debounced line state synchronous to core_clk_i and a
// register master that never strobes read and write together
// register port: strobes one cycle long, read data one cycle later
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps

module lei_top (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire lei_pkg::lei_bus_req_t bus_i,
  input wire logic [15:0] line_state_i,
  output logic [31:0] rdata_o,
  output logic irq_o
);

  import lei_pkg::*;

  // the whole block state, registered once per clock
  lei_state_t st_q;
  lei_state_t st_d;

  // decode and edge terms shared by the next-state logic and the checks
  lei_sel_t sel;
  logic [15:0] rise_ev;
  logic [15:0] fall_ev;
  logic [31:0] set_vec;
  logic [31:0] clr_vec;
  logic [31:0] read_val;
  logic irq_any;

  // address decode; unmapped offsets select nothing
  // full 12-bit compare, so aliases of the offsets stay unmapped
  always_comb begin
    unique case (bus_i.addr)
      LEI_OFS_ENABLE: begin
        sel = LEI_SEL_ENABLE;
      end
      LEI_OFS_PENDING: begin
        sel = LEI_SEL_PENDING;
      end
      LEI_OFS_CTRL: begin
        sel = LEI_SEL_CTRL;
      end
      default: begin
        sel = LEI_SEL_NONE;
      end
    endcase
  end

  // transitions of the debounced state, whatever the line direction
  // the first cycle after reset only samples, so a line that is
  // already high at release does not fake a rising edge
  // a pulse shorter than one clock is lost; the debouncer upstream makes that moot
  always_comb begin
    rise_ev = '0;
    fall_ev = '0;
    if (st_q.primed) begin
      rise_ev = line_state_i & ~st_q.line_prev;
      fall_ev = ~line_state_i & st_q.line_prev;
    end
  end

  // pending set terms, each gated by its own arming bit
  always_comb begin
    set_vec = '0;
    set_vec[LEI_FALL_LSB +: LEI_LINES] =
      fall_ev & st_q.enable[LEI_FALL_LSB +: LEI_LINES];
    set_vec[LEI_RISE_LSB +: LEI_LINES] =
      rise_ev & st_q.enable[LEI_RISE_LSB +: LEI_LINES];
  end

  // write-one-to-clear on the pending register; zeros are ignored
  // whole-word writes only; there are no byte lanes
  always_comb begin
    clr_vec = '0;
    if (bus_i.we && sel == LEI_SEL_PENDING) begin
      clr_vec = bus_i.wdata;
    end
  end

  // read multiplexer; unmapped and reserved bits read as zero
  // a read has no side effect, so polling the status is safe
  always_comb begin
    read_val = LEI_RDATA_IDLE;
    unique case (sel)
      LEI_SEL_ENABLE: begin
        read_val = st_q.enable;
      end
      LEI_SEL_PENDING: begin
        read_val = st_q.pending;
      end
      LEI_SEL_CTRL: begin
        read_val[LEI_GLOBAL_EN_BIT] = st_q.global_irq_enable;
      end
      LEI_SEL_NONE: begin
        read_val = LEI_RDATA_IDLE;
      end
    endcase
  end

  // next state of the whole block
  always_comb begin
    st_d = st_q;
    st_d.line_prev = line_state_i;
    st_d.primed = 1'b1;
    // a set in the same cycle as its clear wins, so no edge is lost
    st_d.pending = (st_q.pending & ~clr_vec) | set_vec;
    // software writes take effect at the strobe edge; no wait state
    if (bus_i.we && sel == LEI_SEL_ENABLE) begin
      st_d.enable = bus_i.wdata;
    end
    if (bus_i.we && sel == LEI_SEL_CTRL) begin
      st_d.global_irq_enable = bus_i.wdata[LEI_GLOBAL_EN_BIT];
    end
    // read data stands only in the cycle after the strobe
    st_d.rdata = LEI_RDATA_IDLE;
    if (bus_i.re) begin
      st_d.rdata = read_val;
    end
  end

  // state register
  // async reset so the interrupt output is quiet before the first clock
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q.enable <= LEI_ENABLE_RST;
      st_q.pending <= LEI_PENDING_RST;
      st_q.global_irq_enable <= LEI_CTRL_RST;
      st_q.line_prev <= LEI_LINE_RST;
      st_q.primed <= 1'b0;
      st_q.rdata <= LEI_RDATA_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // level interrupt; disarming a line masks its stale pending bit
  // as well, which lets software mute a line without losing its status
  assign irq_any = |(st_q.pending & st_q.enable);
  assign irq_o = st_q.global_irq_enable & irq_any;
  assign rdata_o = st_q.rdata;

  // checks on the block's own behaviour
  // sampled on the core clock and silenced while reset is high, so the
  // reset values themselves are checked by the bench instead
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  // register port events; the pending write and read are each used by several checks
  sequence s_pend_write;
    bus_i.we && sel == LEI_SEL_PENDING;
  endsequence

  sequence s_pend_read;
    bus_i.re && sel == LEI_SEL_PENDING;
  endsequence

  sequence s_ctrl_write_off;
    bus_i.we && sel == LEI_SEL_CTRL && !bus_i.wdata[LEI_GLOBAL_EN_BIT];
  endsequence

  // plain register loads, one strobe edge each
  sequence s_enable_write;
    bus_i.we && sel == LEI_SEL_ENABLE;
  endsequence

  sequence s_ctrl_write;
    bus_i.we && sel == LEI_SEL_CTRL;
  endsequence

  // per-line edge to pending relation
  for (genvar n = 0; n < LEI_LINES; n++) begin : g_line_chk
    a_fall_sets_pend: assert property (
      st_q.primed && st_q.line_prev[n] && !line_state_i[n]
        && st_q.enable[LEI_FALL_LSB + n]
      |=> st_q.pending[LEI_FALL_LSB + n])
      else $error("armed falling edge did not set its pending bit");

    a_rise_sets_pend: assert property (
      st_q.primed && !st_q.line_prev[n] && line_state_i[n]
        && st_q.enable[LEI_RISE_LSB + n]
      |=> st_q.pending[LEI_RISE_LSB + n])
      else $error("armed rising edge did not set its pending bit");

    // a set bit survives every cycle without a write of one to it
    a_fall_held: assert property (
      st_q.pending[LEI_FALL_LSB + n]
        && !(bus_i.we && sel == LEI_SEL_PENDING && bus_i.wdata[LEI_FALL_LSB + n])
      |=> st_q.pending[LEI_FALL_LSB + n])
      else $error("falling pending bit dropped without a write of one");

    a_rise_held: assert property (
      st_q.pending[LEI_RISE_LSB + n]
        && !(bus_i.we && sel == LEI_SEL_PENDING && bus_i.wdata[LEI_RISE_LSB + n])
      |=> st_q.pending[LEI_RISE_LSB + n])
      else $error("rising pending bit dropped without a write of one");
  end

  a_fall_arm_only: assert property (
    ((st_q.pending & ~$past(st_q.pending)) >> LEI_FALL_LSB)
      == (((st_q.pending & ~$past(st_q.pending)) >> LEI_FALL_LSB)
        & ($past(st_q.enable) >> LEI_FALL_LSB)))
    else $error("falling pending bit set on a disarmed line");

  a_rise_arm_only: assert property (
    ((st_q.pending & ~$past(st_q.pending)) & 32'h0000_ffff)
      == ((st_q.pending & ~$past(st_q.pending)) & $past(st_q.enable)
        & 32'h0000_ffff))
    else $error("rising pending bit set on a disarmed line");

  // a control write may switch the enable back on in the very next cycle
  a_irq_gated_glob: assert property (
    s_ctrl_write_off |=> !irq_o ##1 (!irq_o || $past(bus_i.we && sel == LEI_SEL_CTRL)))
    else $error("interrupt raised while global enable is off");

  a_stat_read_hi: assert property (
    s_pend_read |=> rdata_o[31:16] == $past(st_q.pending[31:16]))
    else $error("falling pending half read back wrong");

  // a back-to-back read may fill the second cycle with its own data
  a_stat_read_lo: assert property (
    s_pend_read |=> rdata_o[15:0] == $past(st_q.pending[15:0])
      ##1 (rdata_o == '0 || $past(bus_i.re)))
    else $error("rising pending half read back wrong or held too long");

  a_w1c_clears: assert property (
    s_pend_write ##0 (set_vec == '0)
    |=> (st_q.pending & $past(bus_i.wdata)) == '0)
    else $error("write of one left a pending bit set");

  a_edge_from_line: assert property (
    st_q.primed ##1 (line_state_i != $past(line_state_i)) && st_q.enable == '1
    |=> st_q.pending != '0)
    else $error("line transition with all edges armed left no pending bit");

  a_zero_keeps: assert property (
    s_pend_write
    |=> ($past(st_q.pending) & ~$past(bus_i.wdata) & ~st_q.pending) == '0)
    else $error("pending bit lost by a write of zero");

  a_irq_holds: assert property (
    st_q.global_irq_enable && (st_q.pending & st_q.enable) != '0
    |-> irq_o ##1 (irq_o || !st_q.global_irq_enable
      || (st_q.pending & st_q.enable) == '0))
    else $error("interrupt dropped while an enabled request remains");

  // register loads land on the edge after the strobe
  a_enable_loads: assert property (
    s_enable_write |=> st_q.enable == $past(bus_i.wdata))
    else $error("enable register did not take the written word");

  // without a write the arming bits never move
  a_enable_held: assert property (
    !(bus_i.we && sel == LEI_SEL_ENABLE) |=> $stable(st_q.enable))
    else $error("enable register changed without a write");

  a_ctrl_loads: assert property (
    s_ctrl_write |=> st_q.global_irq_enable == $past(bus_i.wdata[LEI_GLOBAL_EN_BIT]))
    else $error("global enable did not take the written bit");

  // without a control write the global enable never moves
  a_ctrl_held: assert property (
    !(bus_i.we && sel == LEI_SEL_CTRL) |=> $stable(st_q.global_irq_enable))
    else $error("global enable changed without a write");

  // reserved control bits read as zero
  a_ctrl_read: assert property (
    bus_i.re && sel == LEI_SEL_CTRL
    |=> (rdata_o >> LEI_GLOBAL_EN_BIT) == 32'($past(st_q.global_irq_enable)))
    else $error("control register read back wrong");

  // read data stand one cycle only, so a quiet port reads zero
  a_rdata_idle: assert property (
    !bus_i.re |=> rdata_o == LEI_RDATA_IDLE)
    else $error("read data left standing without a read");

  // reading the status never clears it; only a write of one does
  a_read_keeps: assert property (
    s_pend_read ##0 !bus_i.we
    |=> (st_q.pending & $past(st_q.pending)) == $past(st_q.pending))
    else $error("status read lost a pending bit");

  // an unmapped write leaves the enable and control registers alone
  a_unmapped_wr: assert property (
    bus_i.we && sel == LEI_SEL_NONE
    |=> $stable(st_q.enable) && $stable(st_q.global_irq_enable))
    else $error("unmapped write changed a register");

  // an edge and its clear in one cycle: the edge must not be lost
  a_set_lands: assert property (
    set_vec != '0 |=> (st_q.pending & $past(set_vec)) == $past(set_vec))
    else $error("armed edge lost against a clear in the same cycle");

  // pending bits rise only through an armed edge
  a_no_stray_set: assert property (
    ((st_q.pending & ~$past(st_q.pending)) & ~$past(set_vec)) == '0)
    else $error("pending bit set without an armed edge");

  // the first edge after reset only samples the lines
  a_first_no_edge: assert property (
    !st_q.primed |=> st_q.pending == LEI_PENDING_RST)
    else $error("edge taken in the first cycle after reset");

endmodule

// ---- tb/lei_line_model.sv ----
// model of the sixteen debounced ttl lines on the far side of the block
// assumes the bench names the wanted levels; lines move one edge later
`timescale 1ns/1ps

module lei_line_model (
  input wire logic clk_i,
  input wire logic [15:0] want_i,
  output logic [15:0] line_o
);
  // debounced levels change only just after an edge, so no glitch reaches the block
  initial line_o = 16'h0000;
  always @(posedge clk_i) begin
    line_o <= want_i;
  end
endmodule

// ---- tb/tb_top.sv ----
// self-checking bench for the line edge interrupt block
// assumes lei_pkg, lei_top and the line model are compiled first
`timescale 1ns/1ps

module tb_top;
  import lei_pkg::*;
  typedef struct packed {
    logic [31:0] en;
    logic [15:0] l0;
    logic [15:0] l1;
    logic [31:0] pend;
  } lei_row_t;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  lei_bus_req_t bus = '0;
  logic [15:0] want = 16'h0000;
  logic [15:0] line_state;
  logic [31:0] rdata_o;
  logic irq_o;
  logic [31:0] rv;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;
  // enable, start lines, end lines, expected pending
  lei_row_t rows [5] = '{
    '{32'h0000_0001, 16'h0000, 16'h0001, 32'h0000_0001},
    '{32'h8000_0000, 16'hffff, 16'h7fff, 32'h8000_0000},
    '{32'hffff_0000, 16'h0000, 16'hffff, 32'h0000_0000},
    '{32'h0000_ffff, 16'hffff, 16'h0000, 32'h0000_0000},
    '{32'hffff_ffff, 16'h00ff, 16'hff00, 32'h00ff_ff00}};

  initial forever #20 core_clk_i = ~core_clk_i;

  lei_top u_lei_top (.core_clk_i(core_clk_i), .rst_i(rst_i), .bus_i(bus), .line_state_i(line_state),
    .rdata_o(rdata_o), .irq_o(irq_o));
  lei_line_model u_lei_line_model (.clk_i(core_clk_i), .want_i(want), .line_o(line_state));

  task automatic summarize();
    $display("checks %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // strobe one cycle, then a quiet cycle so no strobe is assigned twice at one edge
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus.addr <= a;
    bus.wdata <= d;
    bus.we <= 1'b1;
    @(posedge core_clk_i);
    bus.we <= 1'b0;
    @(posedge core_clk_i);
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    bus.addr <= a;
    bus.re <= 1'b1;
    @(posedge core_clk_i);
    bus.re <= 1'b0;
    #1 d = rdata_o;
    @(posedge core_clk_i);
  endtask

  // irq_o is looked at mid-cycle, then the task returns on a rising edge
  task automatic chk_irq(input logic e);
    @(negedge core_clk_i);
    chk({31'h0, irq_o}, {31'h0, e});
    @(posedge core_clk_i);
  endtask

  // ceiling far above the roughly 165 cycles the sequence needs
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      summarize();
    end
  end

  initial begin
    repeat (10) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(negedge core_clk_i);
    chk(rdata_o, 32'h0);
    chk_irq(1'b0);
    rd(LEI_OFS_ENABLE, rv); chk(rv, 32'h0);
    rd(LEI_OFS_PENDING, rv); chk(rv, 32'h0);
    rd(LEI_OFS_CTRL, rv); chk(rv, 32'h0);
    rd(12'h120, rv); chk(rv, 32'h0);
    wr(LEI_OFS_CTRL, 32'h1);
    rd(LEI_OFS_CTRL, rv); chk(rv, 32'h1);
    wr(12'h120, 32'hffff_ffff);
    rd(LEI_OFS_ENABLE, rv); chk(rv, 32'h0);
    $display("reset and map test done");
    foreach (rows[i]) begin
      wr(LEI_OFS_ENABLE, 32'h0);
      wr(LEI_OFS_PENDING, 32'hffff_ffff);
      want <= rows[i].l0;
      repeat (4) @(posedge core_clk_i);
      wr(LEI_OFS_ENABLE, rows[i].en);
      want <= rows[i].l1;
      repeat (4) @(posedge core_clk_i);
      rd(LEI_OFS_PENDING, rv); chk(rv, rows[i].pend);
      chk_irq(|(rows[i].pend & rows[i].en));
      $display("edge row %0d done", i);
    end
    // master enable off: pending still marks, output stays low
    wr(LEI_OFS_CTRL, 32'h0);
    wr(LEI_OFS_PENDING, 32'hffff_ffff);
    wr(LEI_OFS_ENABLE, 32'h1);
    want <= 16'hff01;
    repeat (4) @(posedge core_clk_i);
    chk_irq(1'b0);
    rd(LEI_OFS_PENDING, rv); chk(rv, 32'h1);
    wr(LEI_OFS_PENDING, 32'h0);
    rd(LEI_OFS_PENDING, rv); chk(rv, 32'h1);
    wr(LEI_OFS_CTRL, 32'h1);
    chk_irq(1'b1);
    wr(LEI_OFS_ENABLE, 32'h0);
    chk_irq(1'b0);
    rd(LEI_OFS_PENDING, rv); chk(rv, 32'h1);
    wr(LEI_OFS_ENABLE, 32'h1);
    chk_irq(1'b1);
    wr(LEI_OFS_PENDING, 32'h1);
    chk_irq(1'b0);
    rd(LEI_OFS_PENDING, rv); chk(rv, 32'h0);
    $display("mask and clear test done");
    // a rising edge and its clear meet at one edge: the set wins
    want <= 16'hff00;
    repeat (4) @(posedge core_clk_i);
    want <= 16'hff01;
    @(posedge core_clk_i);
    wr(LEI_OFS_PENDING, 32'h1);
    rd(LEI_OFS_PENDING, rv); chk(rv, 32'h1);
    chk_irq(1'b1);
    $display("set against clear test done");
    // reset in mid-run with a request pending and a line held high
    rst_i <= 1'b1;
    chk_irq(1'b0);
    rst_i <= 1'b0;
    rd(LEI_OFS_PENDING, rv); chk(rv, 32'h0);
    rd(LEI_OFS_ENABLE, rv); chk(rv, 32'h0);
    rd(LEI_OFS_CTRL, rv); chk(rv, 32'h0);
    chk_irq(1'b0);
    $display("mid-run reset test done");
    summarize();
  end
endmodule
